//--- verilog/rsc_map.vh
/*
 * Register map, field positions, codes and timing for the reset source
 * controller. Included by the controller; holds definitions only.
 */
`ifndef RSC_MAP_VH
`define RSC_MAP_VH

// Register byte offsets on the APB bus.
`define RSC_OFF_THR 8'h00
`define RSC_OFF_CTRL 8'h04
`define RSC_OFF_WATCHDOG_CONTROL 8'h08
`define RSC_OFF_STAT 8'h0c

// Control register fields.
`define RSC_CTRL_WRF 0
`define RSC_CTRL_LRF 1
`define RSC_CTRL_LOW_VOLTAGE_FLAG 2
`define RSC_CTRL_KEEP 7

// Status register fields.
`define RSC_STAT_PDF 0
`define RSC_STAT_TO 1
`define RSC_STAT_SLEEP 2

// Watchdog control fields.
`define RSC_WE_HI 7
`define RSC_WE_LO 3

// Threshold select codes.
`define RSC_THR_1V7 8'h66
`define RSC_THR_1V9 8'h55
`define RSC_THR_2V55 8'h33
`define RSC_THR_3V15 8'h99
`define RSC_THR_3V8 8'haa
`define RSC_THR_OFF 8'hf0

// Watchdog enable codes and reset values.
`define RSC_WE_DIS 5'h15
`define RSC_WE_EN 5'h0a
`define RSC_WATCHDOG_CONTROL_POR 8'h53
`define RSC_THR_POR 8'h66

// Slow oscillator edges counted before a bad-code reset.
`define RSC_BAD_EDGES 2'h2

// Low-supply qualification time in ns and the clock period in ns.
`define RSC_T_QUAL_NS 100000
`define RSC_CLK_NS 50

`endif

//--- verilog/rsc_reset_ctrl.v
/*
 * Reset source controller: power-on, qualified low-supply, bad threshold
 * code and bad watchdog code resets, watchdog time-out handling and the
 * reset-cause flags, with an APB register slave.
 * Assumes the supply comparator, the watchdog counter, the power mode and
 * the slow internal oscillator level are synchronous to pclk, and that
 * presetn is the power-on reset.
 */
`include "rsc_map.vh"
`timescale 1ns/1ps
`default_nettype none

module rsc_reset_ctrl #(
    parameter QUAL_NS = `RSC_T_QUAL_NS,
    parameter PORT_W = 8,
    parameter AN_W = 8
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire supply_low,
    input wire wdt_timeout,
    input wire sleep_mode,
    input wire slow_internal_osc,
    output reg sys_reset_r,
    output reg pc_clear_r,
    output reg sp_top_r,
    output reg int_en_clear_r,
    output reg wdt_clear_r,
    output reg timer_off_r,
    output reg [PORT_W-1:0] port_data_init_r,
    output reg [PORT_W-1:0] port_dir_init_r,
    output reg [AN_W-1:0] analog_inputs_r,
    output wire [7:0] threshold_code,
    output wire supply_monitor_on,
    output wire watchdog_enable,
    output wire idle_sysclk_keep
);

    ////////////////////////////////////////////////////////////////////////
    // Timing constants.

    // Qualification in whole cycles; the monitor fires one cycle beyond it.
    localparam integer QUAL_CYC_I = (QUAL_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS;
    localparam integer QUAL_CYC_S = (QUAL_CYC_I < 1) ? 1 : QUAL_CYC_I;
    localparam [15:0] QUAL_CYC = QUAL_CYC_S[15:0];

    ////////////////////////////////////////////////////////////////////////
    // Code checks.

    // True for one of the six defined threshold codes.
    function thr_valid;
        input [7:0] c;
        begin
            case (c)
                `RSC_THR_1V7, `RSC_THR_1V9, `RSC_THR_2V55,
                `RSC_THR_3V15, `RSC_THR_3V8, `RSC_THR_OFF:
                    thr_valid = 1'b1;
                default:
                    thr_valid = 1'b0;
            endcase
        end
    endfunction

    // True for the enable or disable watchdog code.
    function we_valid;
        input [4:0] c;
        begin
            we_valid = (c == `RSC_WE_DIS) || (c == `RSC_WE_EN);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State.

    reg [7:0] thr_r;
    reg [7:0] watchdog_control_r;
    reg low_voltage_flag_r;
    reg lrf_r;
    reg wrf_r;
    reg keep_r;
    reg to_r;
    reg pdf_r;
    reg por_pend_r;
    reg [15:0] qual_cnt_r;
    reg osc_prev_r;
    reg [1:0] thr_bad_cnt_r;
    reg [1:0] we_bad_cnt_r;

    wire osc_rise;
    wire thr_bad;
    wire we_bad;
    wire lvr_fire;
    wire thr_fire;
    wire we_fire;
    wire wdt_run_fire;
    wire wdt_sleep_fire;
    wire full_reset;
    wire wr_acc;
    wire wr_thr;
    wire wr_ctrl;
    wire wr_watchdog_control;
    reg [31:0] rd_nxt;
    reg err_nxt;

    assign osc_rise = slow_internal_osc & ~osc_prev_r;
    assign thr_bad = ~thr_valid(thr_r);
    assign we_bad = ~we_valid(watchdog_control_r[`RSC_WE_HI:`RSC_WE_LO]);
    assign supply_monitor_on = (thr_r != `RSC_THR_OFF) & ~sleep_mode;
    assign watchdog_enable = (watchdog_control_r[`RSC_WE_HI:`RSC_WE_LO] == `RSC_WE_EN);
    assign threshold_code = thr_r;
    assign idle_sysclk_keep = keep_r;

    // A low level that reaches the count persisted beyond the limit.
    assign lvr_fire = supply_monitor_on & supply_low & (qual_cnt_r == QUAL_CYC);
    assign thr_fire = thr_bad & osc_rise & (thr_bad_cnt_r == `RSC_BAD_EDGES);
    assign we_fire = we_bad & osc_rise & (we_bad_cnt_r == `RSC_BAD_EDGES);
    assign wdt_run_fire = wdt_timeout & ~sleep_mode;
    assign wdt_sleep_fire = wdt_timeout & sleep_mode;
    assign full_reset = por_pend_r | lvr_fire | thr_fire | we_fire | wdt_run_fire;

    // Writes take effect at the access edge with pready high.
    assign wr_acc = psel & penable & pwrite & pready;
    assign wr_thr = wr_acc & (paddr == `RSC_OFF_THR);
    assign wr_ctrl = wr_acc & (paddr == `RSC_OFF_CTRL);
    assign wr_watchdog_control = wr_acc & (paddr == `RSC_OFF_WATCHDOG_CONTROL);

    ////////////////////////////////////////////////////////////////////////
    // Supply qualification counter; restarts whenever the supply recovers.

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            qual_cnt_r <= 16'h0000;
        else if (!(supply_monitor_on & supply_low) || full_reset)
            qual_cnt_r <= 16'h0000;
        else if (qual_cnt_r != QUAL_CYC)
            qual_cnt_r <= qual_cnt_r + 16'h0001;
    end

    ////////////////////////////////////////////////////////////////////////
    // Slow oscillator edge counting for the bad-code resets.

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            osc_prev_r <= 1'b0;
            thr_bad_cnt_r <= 2'h0;
            we_bad_cnt_r <= 2'h0;
        end
        else
        begin
            osc_prev_r <= slow_internal_osc;
            if (!thr_bad || full_reset)
                thr_bad_cnt_r <= 2'h0;
            else if (osc_rise && thr_bad_cnt_r != `RSC_BAD_EDGES)
                thr_bad_cnt_r <= thr_bad_cnt_r + 2'h1;
            if (!we_bad || full_reset)
                we_bad_cnt_r <= 2'h0;
            else if (osc_rise && we_bad_cnt_r != `RSC_BAD_EDGES)
                we_bad_cnt_r <= we_bad_cnt_r + 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Threshold select and watchdog control registers.

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            thr_r <= `RSC_THR_POR;
            watchdog_control_r <= `RSC_WATCHDOG_CONTROL_POR;
        end
        else
        begin
            // A genuine low-supply reset leaves the threshold alone.
            if (thr_fire)
                thr_r <= `RSC_THR_POR;
            else if (wr_thr && !full_reset)
                thr_r <= pwdata[7:0];
            if (full_reset)
                watchdog_control_r <= `RSC_WATCHDOG_CONTROL_POR;
            else if (wr_watchdog_control)
                watchdog_control_r <= pwdata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset-cause flags in the control register; hardware set wins.

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            low_voltage_flag_r <= 1'b0;
            lrf_r <= 1'b0;
            wrf_r <= 1'b0;
            keep_r <= 1'b0;
        end
        else
        begin
            if (lvr_fire)
                low_voltage_flag_r <= 1'b1;
            else if (wr_ctrl && !pwdata[`RSC_CTRL_LOW_VOLTAGE_FLAG])
                low_voltage_flag_r <= 1'b0;
            if (thr_fire)
                lrf_r <= 1'b1;
            else if (wr_ctrl && !pwdata[`RSC_CTRL_LRF])
                lrf_r <= 1'b0;
            if (we_fire)
                wrf_r <= 1'b1;
            else if (wr_ctrl && !pwdata[`RSC_CTRL_WRF])
                wrf_r <= 1'b0;
            if (full_reset)
                keep_r <= 1'b0;
            else if (wr_ctrl)
                keep_r <= pwdata[`RSC_CTRL_KEEP];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Time-out and power-down flags, cleared only by power-on.

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            to_r <= 1'b0;
            pdf_r <= 1'b0;
        end
        else if (wdt_sleep_fire)
        begin
            to_r <= 1'b1;
            pdf_r <= 1'b1;
        end
        else if (wdt_run_fire)
            to_r <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset pulses to the core and peripherals.

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            por_pend_r <= 1'b1;
            sys_reset_r <= 1'b0;
            pc_clear_r <= 1'b0;
            sp_top_r <= 1'b0;
            int_en_clear_r <= 1'b0;
            wdt_clear_r <= 1'b0;
            timer_off_r <= 1'b0;
        end
        else
        begin
            por_pend_r <= 1'b0;
            sys_reset_r <= full_reset;
            pc_clear_r <= full_reset | wdt_sleep_fire;
            sp_top_r <= full_reset | wdt_sleep_fire;
            int_en_clear_r <= full_reset;
            wdt_clear_r <= full_reset;
            timer_off_r <= full_reset;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Port and analogue pin initial values, reloaded on each full reset.

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            port_data_init_r <= {PORT_W{1'b1}};
            port_dir_init_r <= {PORT_W{1'b1}};
            analog_inputs_r <= {AN_W{1'b1}};
        end
        else if (full_reset)
        begin
            port_data_init_r <= {PORT_W{1'b1}};
            port_dir_init_r <= {PORT_W{1'b1}};
            analog_inputs_r <= {AN_W{1'b1}};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB read mux; unmapped offsets answer with an error.

    always @*
    begin
        rd_nxt = 32'h0000_0000;
        err_nxt = 1'b0;
        case (paddr)
            `RSC_OFF_THR:
                rd_nxt[7:0] = thr_r;
            `RSC_OFF_CTRL:
            begin
                rd_nxt[`RSC_CTRL_KEEP] = keep_r;
                rd_nxt[`RSC_CTRL_LOW_VOLTAGE_FLAG] = low_voltage_flag_r;
                rd_nxt[`RSC_CTRL_LRF] = lrf_r;
                rd_nxt[`RSC_CTRL_WRF] = wrf_r;
            end
            `RSC_OFF_WATCHDOG_CONTROL:
                rd_nxt[7:0] = watchdog_control_r;
            `RSC_OFF_STAT:
            begin
                rd_nxt[`RSC_STAT_PDF] = pdf_r;
                rd_nxt[`RSC_STAT_TO] = to_r;
                rd_nxt[`RSC_STAT_SLEEP] = sleep_mode;
            end
            default:
                err_nxt = 1'b1;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // APB answer: data captured in setup, pready high for one access cycle.

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else if (psel && !penable)
        begin
            prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
            pready <= 1'b1;
            pslverr <= err_nxt;
        end
        else
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

endmodule

`default_nettype wire

//--- verif/rsc_ctrl_chk_sva.sv
/* Assertion checker for the reset source controller ports.
   Assumes it is bound into rsc_reset_ctrl and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module rsc_ctrl_chk #(
    parameter QUAL_NS = 500,
    parameter PORT_W = 8
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire [7:0] paddr,
    input wire pready,
    input wire pslverr,
    input wire supply_low,
    input wire wdt_timeout,
    input wire sleep_mode,
    input wire sys_reset_r,
    input wire pc_clear_r,
    input wire sp_top_r,
    input wire int_en_clear_r,
    input wire [PORT_W-1:0] port_dir_init_r,
    input wire [7:0] threshold_code,
    input wire supply_monitor_on
);
    localparam int QUAL_CYC = (QUAL_NS + 49) / 50;
    logic [15:0] low_cnt_r;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////
    // Counts the unbroken low-supply cycles that the monitor may see.
    always @(posedge pclk or negedge presetn)
        if (!presetn)
            low_cnt_r <= 16'h0000;
        else if (supply_low && supply_monitor_on && !sys_reset_r)
            low_cnt_r <= low_cnt_r + 16'h0001;
        else
            low_cnt_r <= 16'h0000;
    ////////////////////////////////////////////////////////////////
    // The properties tie reset outputs to their causes, and check the monitor enable and the APB answer.
    a_por_pulse: assert property ($rose(presetn) |-> ##[1:2] sys_reset_r)
        else $error("no power-on pulse");
    a_full_set: assert property (sys_reset_r |-> pc_clear_r && sp_top_r && int_en_clear_r)
        else $error("full reset incomplete");
    a_wdt_run: assert property (wdt_timeout && !sleep_mode |=> sys_reset_r)
        else $error("run time-out without reset");
    a_wdt_sleep: assert property (wdt_timeout && sleep_mode |=> pc_clear_r && sp_top_r && !sys_reset_r)
        else $error("sleep time-out wrong");
    a_port_ones: assert property (&port_dir_init_r)
        else $error("port direction not inputs");
    a_mon_sleep: assert property (sleep_mode |-> !supply_monitor_on)
        else $error("monitor on in sleep");
    a_mon_off: assert property (threshold_code == 8'hf0 |-> !supply_monitor_on)
        else $error("monitor on when disabled");
    a_lvr_qual: assert property (low_cnt_r == QUAL_CYC + 1 |-> sys_reset_r)
        else $error("qualified low supply ignored");
    a_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("ready not one cycle");
    a_unmapped: assert property (pready && paddr > 8'h0c |-> pslverr)
        else $error("unmapped access accepted");
    c_lvr: cover property (low_cnt_r == QUAL_CYC + 1);
    c_wdt_sleep: cover property (wdt_timeout && sleep_mode);
    c_slverr: cover property (pready && pslverr);
endmodule
bind rsc_reset_ctrl rsc_ctrl_chk #(.QUAL_NS(QUAL_NS), .PORT_W(PORT_W)) u_rsc_ctrl_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
    .pready(pready), .pslverr(pslverr), .supply_low(supply_low), .wdt_timeout(wdt_timeout),
    .sleep_mode(sleep_mode), .sys_reset_r(sys_reset_r), .pc_clear_r(pc_clear_r),
    .sp_top_r(sp_top_r), .int_en_clear_r(int_en_clear_r), .port_dir_init_r(port_dir_init_r),
    .threshold_code(threshold_code), .supply_monitor_on(supply_monitor_on)
);
`default_nettype wire

//--- verif/reset_source_controller_tb.sv
/* Self-checking bench for the reset source controller.
   Assumes the controller and its checker are compiled alongside. */
`timescale 1ns/1ps
`default_nettype none
module reset_source_controller_tb;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic supply_low = 1'b0, wdt_timeout = 1'b0, sleep_mode = 1'b0, slow_internal_osc = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, lfsr_r = 32'h020bb449;
    logic pready, pslverr, sys_reset_r, keep, wen, err, mon_on, pcc, wclr, toff;
    logic [7:0] thr_code, pdata, ana;
    logic [2:0] osc_cnt = 3'h0;
    logic [7:0] codes [6] = '{8'h55, 8'h33, 8'h99, 8'haa, 8'hf0, 8'h66};
    int mismatches = 0, checks = 0, nres = 0, npc = 0, n, m, t, i;
    rsc_reset_ctrl #(.QUAL_NS(500)) u_rsc_reset_ctrl (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .supply_low(supply_low), .wdt_timeout(wdt_timeout), .sleep_mode(sleep_mode),
        .slow_internal_osc(slow_internal_osc), .sys_reset_r(sys_reset_r), .pc_clear_r(pcc),
        .sp_top_r(), .int_en_clear_r(), .wdt_clear_r(wclr), .timer_off_r(toff), .port_data_init_r(pdata),
        .port_dir_init_r(), .analog_inputs_r(ana), .threshold_code(thr_code), .supply_monitor_on(mon_on),
        .watchdog_enable(wen), .idle_sysclk_keep(keep)
    );
    ////////////////////////////////////////////////////////////////
    // The clock, a slow oscillator of eight cycles, and a count of resets.
    always #25 pclk = ~pclk;
    always @(posedge pclk)
    begin
        osc_cnt <= osc_cnt + 3'h1;
        slow_internal_osc <= osc_cnt[2];
        if (pcc === 1'b1)
            npc <= npc + 1;
        if (sys_reset_r === 1'b1)
        begin
            nres <= nres + 1;
            chk("reset pulses", 32'h3, {30'h0, wclr, toff});
        end
    end
    ////////////////////////////////////////////////////////////////
    // Helpers for random values, comparisons and bus cycles.
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task final_report;
        if (mismatches == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task fail_wait;
        mismatches++;
        final_report();
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 8 && pready !== 1'b1; k++)
            @(posedge pclk);
        if (k == 8)
            fail_wait();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), e, rd);
    endtask
    task waitrs(input int lim);
        t = -1;
        for (i = 0; i < lim && t < 0; i++)
        begin
            @(posedge pclk);
            if (sys_reset_r === 1'b1)
                t = i;
        end
        if (t < 0)
            fail_wait();
    endtask
    ////////////////////////////////////////////////////////////////
    // Cuts a hung run short.
    initial
    begin
        repeat (100000) @(posedge pclk);
        fail_wait();
    end
    // Main sequence.
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        rchk(8'h00, 32'h66);
        rchk(8'h04, 32'h0);
        rchk(8'h08, 32'h53);
        rchk(8'h0c, 32'h0);
        chk("port data", 32'hff, {24'h0, pdata});
        chk("analog pins", 32'hff, {24'h0, ana});
        rchk(8'h10, 32'h0);
        chk("slverr", 32'h1, {31'h0, err});
        n = nres;
        for (i = 0; i < 6; i++)
        begin
            apb(1'b1, 8'h00, {24'h0, codes[i]});
            rchk(8'h00, {24'h0, codes[i]});
            chk("thr code", {24'h0, codes[i]}, {24'h0, thr_code});
        end
        chk("valid codes", n, nres);
        lfsr_r = lfsr(lfsr_r);
        apb(1'b1, 8'h04, {24'h0, lfsr_r[0], 7'h7f});
        rchk(8'h04, {24'h0, lfsr_r[0], 7'h00});
        chk("keep", {31'h0, lfsr_r[0]}, {31'h0, keep});
        supply_low <= 1'b1;
        repeat (5) @(posedge pclk);
        supply_low <= 1'b0;
        repeat (20) @(posedge pclk);
        chk("short low", n, nres);
        apb(1'b1, 8'h00, 32'h55);
        supply_low <= 1'b1;
        waitrs(40);
        supply_low <= 1'b0;
        rchk(8'h04, 32'h04);
        rchk(8'h00, 32'h55);
        rchk(8'h0c, 32'h0);
        apb(1'b1, 8'h04, 32'h0);
        rchk(8'h04, 32'h0);
        wdt_timeout <= 1'b1;
        @(posedge pclk);
        wdt_timeout <= 1'b0;
        waitrs(10);
        rchk(8'h0c, 32'h02);
        n = nres;
        m = npc;
        sleep_mode <= 1'b1;
        supply_low <= 1'b1;
        repeat (30) @(posedge pclk);
        chk("monitor sleep", 32'h0, {31'h0, mon_on});
        supply_low <= 1'b0;
        wdt_timeout <= 1'b1;
        @(posedge pclk);
        wdt_timeout <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("sleep resets", n, nres);
        chk("sleep pc clear", m + 1, npc);
        sleep_mode <= 1'b0;
        @(posedge pclk);
        rchk(8'h0c, 32'h03);
        do lfsr_r = lfsr(lfsr_r);
        while (lfsr_r[7:0] inside {8'h66, 8'h55, 8'h33, 8'h99, 8'haa, 8'hf0});
        apb(1'b1, 8'h00, {24'h0, lfsr_r[7:0]});
        waitrs(40);
        chk("delay", 32'h1, {31'h0, t >= 12 && t <= 28});
        rchk(8'h00, 32'h66);
        rchk(8'h04, 32'h02);
        apb(1'b1, 8'h04, 32'h0);
        do lfsr_r = lfsr(lfsr_r);
        while (lfsr_r[7:3] == 5'h0a || lfsr_r[7:3] == 5'h15);
        apb(1'b1, 8'h08, {24'h0, lfsr_r[7:0]});
        waitrs(40);
        rchk(8'h08, 32'h53);
        rchk(8'h04, 32'h01);
        n = nres;
        apb(1'b1, 8'h08, 32'hab);
        chk("wdt off", 32'h0, {31'h0, wen});
        apb(1'b1, 8'h08, 32'h53);
        chk("wdt on", 32'h1, {31'h0, wen});
        chk("no reset", n, nres);
        final_report();
    end
endmodule
`default_nettype wire
